// File: logic/rtc_serial_dev.sv
/*
  Device end: key matcher, serial transfer engine, BCD timekeeper and
  chip-enable gate for the mated SRAM.
  Assumes link pins are synchronous to clk_i and tick_i pulses at 100 Hz.
*/
// What this block does
// - Unlock after 64 consecutive matching key writes.
// - Before unlock, all cycles above the power fail threshold reach the memory.
// - Next 64 cycles transfer clock data, memory blocked.
// - A read restarts the key pointer.
// - Key writes still reach memory at any address.
// - Host keeps one scratch address for key writes.
// - Match advances pointer from bit zero.
// - Mismatch freezes pointer, later writes ignored.
// - Read during matching aborts and resets pointer.
// - One bit per cycle, direction from strobes.
// - Deselected cycles do not disturb sequences.
// - Eight bytes, bit 0 reg 0 first.
// - Host updates registers as whole bytes.
// - Registers hold BCD values.
// - Key is C5 3A A3 5C twice, LSB first.
// - Hours bit 7 selects 12-hour mode.
// - Hours bit 5 is PM or twenties.
// - Day bit 4 masks the abort pin.
// - Day bit 5 high stops the oscillator.
// - Mask and oscillator bits reset to one.
// - Unused bits read zero, writes ignored.
// - Read is CE low WE high; write CE and WE low.
// - Below power fail threshold all access blocked.
`timescale 1ns/100ps
module rtc_serial_dev
  import rtc_serial_pkg::*;
(
  // Clock, reset and clock enable
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic clk_en_i,
  // Link pins
  sram_link_if.dev  link,
  // Device side
  input  wire logic tick_i,
  input  wire logic abort_n_i,
  input  wire logic power_fail_threshold_i,
  output logic      mem_ce_n_o,
  output logic      xfer_active_o
);
  typedef enum logic [1:0] {ST_KEY = 2'b01, ST_XFER = 2'b10} state_type;

  typedef struct packed {
    state_type       st;
    logic [5:0]      ptr;
    logic            miss;
    logic [5:0]      idx;
    logic [7:0]      acc;
    logic            all_wr;
    logic [63:0]     snap;
    logic [7:0][7:0] rtc;
    logic            prev_rd;
    logic            prev_wr;
    logic            din;
    logic            mem_ce_n;
    logic            dq0;
    logic            dq0_oe_n;
  } dev_state_type;

  dev_state_type s_q;
  dev_state_type s_d;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc

  // Result is {carry, next value}.
  function automatic logic [8:0] step(input logic [7:0] v, input logic [7:0] lo,
                                      input logic [7:0] hi);
    step = (v >= hi) ? {1'b1, lo} : {1'b0, bcd_inc(v)};
  endfunction : step

  function automatic logic [7:0] days_in(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    if (mon == 8'h02) begin
      days_in = leap ? 8'h29 : 8'h28;
    end else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11) begin
      days_in = 8'h30;
    end else begin
      days_in = 8'h31;
    end
  endfunction : days_in

  logic rd_now;
  logic wr_now;
  logic rd_end;
  logic wr_end;
  logic abort;
  logic [8:0] r;
  logic [7:0] h;
  logic       carry;

  always_comb begin
    s_d    = s_q;
    r      = 9'h000;
    h      = 8'h00;
    carry  = 1'b0;
    rd_now = !link.ce_n && link.we_n && !power_fail_threshold_i;
    wr_now = !link.ce_n && !link.we_n && !power_fail_threshold_i;
    // Cycles are counted at their end, so a deselected cycle never counts.
    rd_end = s_q.prev_rd && !rd_now;
    wr_end = s_q.prev_wr && !wr_now;
    abort  = !abort_n_i && !s_q.rtc[REG_DAY][DAY_RST_BIT];
    s_d.prev_rd = rd_now;
    s_d.prev_wr = wr_now;
    if (wr_now) begin
      s_d.din = link.serial_key_data_line;
    end

    // Timekeeping; a stopped oscillator freezes every count.
    if (tick_i && !s_q.rtc[REG_DAY][DAY_OSC_BIT]) begin
      r = step(s_q.rtc[REG_HUND], 8'h00, 8'h99);
      s_d.rtc[REG_HUND] = r[7:0];
      carry = r[8];
      if (carry) begin
        r = step({1'b0, s_q.rtc[REG_SEC][6:0]}, 8'h00, 8'h59);
        s_d.rtc[REG_SEC] = r[7:0];
        carry = r[8];
      end
      if (carry) begin
        r = step({1'b0, s_q.rtc[REG_MIN][6:0]}, 8'h00, 8'h59);
        s_d.rtc[REG_MIN] = r[7:0];
        carry = r[8];
      end
      if (carry) begin
        h = s_q.rtc[REG_HOUR];
        if (h[HOUR_12_BIT]) begin
          carry = 1'b0;
          if (h[4:0] == 5'h12) begin
            h[4:0] = 5'h01;
          end else if (h[4:0] == 5'h11) begin
            h[4:0] = 5'h12;
            carry = h[HOUR_PM_BIT];
            h[HOUR_PM_BIT] = !h[HOUR_PM_BIT];
          end else begin
            r = {1'b0, bcd_inc({3'b000, h[4:0]})};
            h[4:0] = r[4:0];
          end
        end else begin
          r = step({2'b00, h[5:0]}, 8'h00, 8'h23);
          h[5:0] = r[5:0];
          carry = r[8];
        end
        s_d.rtc[REG_HOUR] = h & REG_MASKS[REG_HOUR*8 +: 8];
      end
      if (carry) begin
        r = step({5'b00000, s_q.rtc[REG_DAY][2:0]}, 8'h01, 8'h07);
        s_d.rtc[REG_DAY] = {s_q.rtc[REG_DAY][7:3], r[2:0]};
        r = step(s_q.rtc[REG_DATE],
                 8'h01, days_in(s_q.rtc[REG_MONTH], s_q.rtc[REG_YEAR]));
        s_d.rtc[REG_DATE] = r[7:0];
        carry = r[8];
      end
      if (carry) begin
        r = step(s_q.rtc[REG_MONTH], 8'h01, 8'h12);
        s_d.rtc[REG_MONTH] = r[7:0];
        carry = r[8];
      end
      if (carry) begin
        r = step(s_q.rtc[REG_YEAR], 8'h00, 8'h99);
        s_d.rtc[REG_YEAR] = r[7:0];
      end
    end

    case (s_q.st)
      ST_KEY: begin
        if (rd_end) begin
          s_d.ptr  = 6'h00;
          s_d.miss = 1'b0;
        end else if (wr_end && !s_q.miss) begin
          if (s_q.din == UNLOCK_KEY[s_q.ptr]) begin
            if (s_q.ptr == LAST_BIT) begin
              s_d.st     = ST_XFER;
              s_d.ptr    = 6'h00;
              s_d.miss   = 1'b1;
              s_d.idx    = 6'h00;
              s_d.all_wr = 1'b1;
              s_d.snap   = s_q.rtc;
            end else begin
              s_d.ptr = s_q.ptr + 6'h01;
            end
          end else begin
            s_d.miss = 1'b1;
          end
        end
      end
      ST_XFER: begin
        if (abort) begin
          s_d.st = ST_KEY;
        end else if (rd_end || wr_end) begin
          s_d.acc    = {(wr_end ? s_q.din : s_q.snap[s_q.idx]), s_q.acc[7:1]};
          s_d.all_wr = s_q.all_wr && wr_end;
          if (s_q.idx[2:0] == 3'h7) begin
            // Partly read bytes are never committed, so a mixed byte cannot tear.
            if (s_q.all_wr && wr_end) begin
              s_d.rtc[s_q.idx[5:3]] = {s_q.din, s_q.acc[7:1]}
                                      & REG_MASKS[s_q.idx[5:3]*8 +: 8];
            end
            s_d.all_wr = 1'b1;
          end
          s_d.idx = s_q.idx + 6'h01;
          if (s_q.idx == LAST_BIT) begin
            s_d.st = ST_KEY;
          end
        end
      end
      default: begin
        s_d.st = ST_KEY;
      end
    endcase

    // The RAM only sees chip enable outside transfer and above the threshold.
    s_d.mem_ce_n = link.ce_n || (s_q.st == ST_XFER)
                   || power_fail_threshold_i;
    s_d.dq0      = s_q.snap[s_q.idx];
    s_d.dq0_oe_n = !(rd_now && !link.oe_n && (s_q.st == ST_XFER));
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_q          <= '0;
      s_q.st       <= ST_KEY;
      s_q.miss     <= 1'b1;
      s_q.all_wr   <= 1'b1;
      s_q.rtc      <= REG_RESET;
      s_q.mem_ce_n <= 1'b1;
      s_q.dq0_oe_n <= 1'b1;
    end else if (clk_en_i) begin
      s_q <= s_d;
    end
  end

  assign mem_ce_n_o        = s_q.mem_ce_n;
  // The one-hot code lets this output be a bare flop bit, free of decode glitches.
  assign xfer_active_o     = s_q.st[1];
  assign link.dev_dq0      = s_q.dq0;
  assign link.dev_dq0_oe_n = s_q.dq0_oe_n;
endmodule : rtc_serial_dev

// File: logic/rtc_serial_host.sv
/*
  Host end: an Avalon-MM slave whose orders run one full clock read or
  write as SRAM cycles: restart read, 64 key writes, 64 transfer cycles.
  Assumes the device samples the link on the same clk_i.
*/
`timescale 1ns/100ps
module rtc_serial_host
  import rtc_serial_pkg::*;
#(
  parameter int HADDR_W = ADDR_W
)(
  // Clock, reset and clock enable
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        clk_en_i,
  // Avalon-MM slave
  input  wire logic [3:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [3:0]  byteenable_i,
  input  wire logic [31:0] writedata_i,
  output logic [31:0]      readdata_o,
  output logic             waitrequest_o,
  // Link pins
  sram_link_if.host        link
);
  typedef enum logic [3:0] {
    PH_IDLE = 4'b0001, PH_START = 4'b0010, PH_KEY = 4'b0100, PH_XFER = 4'b1000
  } phase_type;

  typedef struct packed {
    phase_type          ph;
    logic               dir;
    logic [HADDR_W-1:0] scratch;
    logic [63:0]        tx;
    logic [63:0]        rx;
    logic [5:0]         cyc;
    logic               active;
    logic [3:0]         tcnt;
    logic               waitreq;
    logic [31:0]        rdata;
    logic               ce_n;
    logic               oe_n;
    logic               we_n;
    logic               dq;
    logic               dq_oe_n;
  } host_state_type;

  host_state_type s_q;
  host_state_type s_d;
  logic           is_wr;
  logic           bit_out;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction : merge

  always_comb begin
    s_d     = s_q;
    is_wr   = (s_q.ph == PH_KEY) || ((s_q.ph == PH_XFER) && s_q.dir);
    bit_out = (s_q.ph == PH_KEY) ? UNLOCK_KEY[s_q.cyc] : s_q.tx[s_q.cyc];

    // Answer one cycle after the request; the action lands on the accept edge.
    s_d.waitreq = !((read_i || write_i) && s_q.waitreq);
    if (read_i && s_q.waitreq) begin
      if (address_i == OFS_CTRL) begin
        s_d.rdata = {30'h0, s_q.dir, (s_q.ph != PH_IDLE)};
      end else if (address_i == OFS_ADDR) begin
        s_d.rdata = 32'(s_q.scratch);
      end else if (address_i == OFS_DATA_LO) begin
        s_d.rdata = s_q.rx[31:0];
      end else if (address_i == OFS_DATA_HI) begin
        s_d.rdata = s_q.rx[63:32];
      end else begin
        s_d.rdata = 32'h0000_0000;
      end
    end
    if (write_i && !s_q.waitreq) begin
      if (address_i == OFS_CTRL) begin
        if (byteenable_i[0] && writedata_i[CTRL_GO_BIT] && s_q.ph == PH_IDLE) begin
          s_d.ph  = PH_START;
          s_d.dir = writedata_i[CTRL_DIR_BIT];
          s_d.cyc = 6'h00;
        end
      end else if (address_i == OFS_ADDR) begin
        s_d.scratch = HADDR_W'(merge(32'(s_q.scratch), writedata_i, byteenable_i));
      end else if (address_i == OFS_DATA_LO) begin
        s_d.tx[31:0] = merge(s_q.tx[31:0], writedata_i, byteenable_i);
      end else if (address_i == OFS_DATA_HI) begin
        s_d.tx[63:32] = merge(s_q.tx[63:32], writedata_i, byteenable_i);
      end
    end

    if (s_q.ph != PH_IDLE) begin
      if (!s_q.active && s_q.tcnt == 4'h0) begin
        s_d.active  = 1'b1;
        s_d.tcnt    = 4'(STROBE_CYC - 1);
        s_d.ce_n    = 1'b0;
        s_d.we_n    = !is_wr;
        s_d.oe_n    = is_wr;
        s_d.dq      = bit_out;
        s_d.dq_oe_n = !is_wr;
      end else if (s_q.active && s_q.tcnt == 4'h0) begin
        s_d.active  = 1'b0;
        s_d.tcnt    = 4'(RECOVER_CYC - 1);
        s_d.ce_n    = 1'b1;
        s_d.we_n    = 1'b1;
        s_d.oe_n    = 1'b1;
        s_d.dq_oe_n = 1'b1;
        if (s_q.ph == PH_XFER && !s_q.dir) begin
          s_d.rx[s_q.cyc] = link.serial_key_data_line;
        end
        s_d.cyc = s_q.cyc + 6'h01;
        if (s_q.ph == PH_START) begin
          s_d.ph  = PH_KEY;
          s_d.cyc = 6'h00;
        end else if (s_q.cyc == LAST_BIT) begin
          s_d.ph = (s_q.ph == PH_KEY) ? PH_XFER : PH_IDLE;
        end
      end else begin
        s_d.tcnt = s_q.tcnt - 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_q         <= '0;
      s_q.ph      <= PH_IDLE;
      s_q.waitreq <= 1'b1;
      s_q.ce_n    <= 1'b1;
      s_q.oe_n    <= 1'b1;
      s_q.we_n    <= 1'b1;
      s_q.dq_oe_n <= 1'b1;
    end else if (clk_en_i) begin
      s_q <= s_d;
    end
  end

  assign readdata_o        = s_q.rdata;
  assign waitrequest_o     = s_q.waitreq;
  assign link.ce_n         = s_q.ce_n;
  assign link.oe_n         = s_q.oe_n;
  assign link.we_n         = s_q.we_n;
  assign link.addr         = s_q.scratch;
  assign link.host_dq      = {7'h00, s_q.dq};
  assign link.host_dq_oe_n = s_q.dq_oe_n;
endmodule : rtc_serial_host

// File: logic/rtc_serial_pkg.sv
/*
  Shared constants for the hidden serial clock reached through SRAM cycles:
  unlock key, register layout, reset values, masks and host timing.
  Assumes a single 50 MHz clock on both ends of the link.
*/
package rtc_serial_pkg;
  localparam int          CLK_MHZ      = 50;
  localparam int          ADDR_W       = 17;
  localparam int          SEQ_BITS     = 64;
  localparam logic [63:0] UNLOCK_KEY   = 64'h5CA3_3AC5_5CA3_3AC5;
  localparam logic [5:0]  LAST_BIT     = 6'h3F;
  // Register indices inside the eight-byte timekeeping image.
  localparam int          REG_HUND     = 0;
  localparam int          REG_SEC      = 1;
  localparam int          REG_MIN      = 2;
  localparam int          REG_HOUR     = 3;
  localparam int          REG_DAY      = 4;
  localparam int          REG_DATE     = 5;
  localparam int          REG_MONTH    = 6;
  localparam int          REG_YEAR     = 7;
  // Field positions.
  localparam int          HOUR_12_BIT  = 7;
  localparam int          HOUR_PM_BIT  = 5;
  localparam int          DAY_RST_BIT  = 4;
  localparam int          DAY_OSC_BIT  = 5;
  // Writable bits per register; the rest always read zero.
  localparam logic [63:0] REG_MASKS    = 64'hFF1F_3F37_BF7F_7FFF;
  localparam logic [63:0] REG_RESET    = 64'h0001_0131_0000_0000;
  // Host register map, byte offsets on the Avalon-MM slave.
  localparam logic [3:0]  OFS_CTRL     = 4'h0;
  localparam logic [3:0]  OFS_ADDR     = 4'h4;
  localparam logic [3:0]  OFS_DATA_LO  = 4'h8;
  localparam logic [3:0]  OFS_DATA_HI  = 4'hC;
  localparam int          CTRL_GO_BIT  = 0;
  localparam int          CTRL_DIR_BIT = 1;
  // Host strobe timing.
  localparam int          STROBE_NS    = 60;
  localparam int          RECOVER_NS   = 20;
  localparam int          STROBE_CYC   = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int          RECOVER_CYC  = (RECOVER_NS * CLK_MHZ + 999) / 1000;
endpackage : rtc_serial_pkg

// File: logic/sram_link_if.sv
/*
  Pin bundle between the SRAM-cycle host and the hidden clock device.
  Assumes both ends share clk_i; the data line level is resolved here.
*/
`timescale 1ns/100ps
interface sram_link_if #(parameter int ADDR_W = 17);
  logic              ce_n;
  logic              oe_n;
  logic              we_n;
  logic [ADDR_W-1:0] addr;
  logic [7:0]        host_dq;
  logic              host_dq_oe_n;
  logic              dev_dq0;
  logic              dev_dq0_oe_n;
  logic              serial_key_data_line;

  // The device only ever drives the lowest data line.
  assign serial_key_data_line = !dev_dq0_oe_n ? dev_dq0 :
                                !host_dq_oe_n ? host_dq[0] : 1'b1;

  modport host (output ce_n, oe_n, we_n, addr, host_dq, host_dq_oe_n,
                input serial_key_data_line);
  modport dev  (input ce_n, oe_n, we_n, serial_key_data_line,
                output dev_dq0, dev_dq0_oe_n);
endinterface : sram_link_if

// File: testbench/hidden_rtc_serial_access_tb.sv
/*
  Bench joining host and device ends over the link, driven over Avalon-MM.
  Assumes one 50 MHz clock; each clock operation takes some 520 cycles.
*/
`timescale 1ns/100ps
module hidden_rtc_serial_access_tb import rtc_serial_pkg::*; ;
  logic        clk_i      = 1'b0;
  logic        reset_i    = 1'b1;
  logic [3:0]  av_address = 4'h0;
  logic        av_read    = 1'b0;
  logic        av_write   = 1'b0;
  logic [31:0] av_wdata   = 32'h0000_0000;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        tick       = 1'b0;
  logic        abort_n    = 1'b1;
  logic        pwr_fail   = 1'b0;
  logic        mem_ce_n;
  logic        xfer_active;
  int          err_total  = 0;
  int          num_checks = 0;
  int          cycles     = 0;

  always #10 clk_i = ~clk_i;

  sram_link_if #(.ADDR_W(ADDR_W)) link ();
  rtc_serial_host u_rtc_serial_host (.clk_i(clk_i), .reset_i(reset_i), .clk_en_i(1'b1),
    .address_i(av_address), .read_i(av_read), .write_i(av_write), .byteenable_i(4'hF),
    .writedata_i(av_wdata), .readdata_o(readdata), .waitrequest_o(waitrequest), .link(link));
  rtc_serial_dev u_rtc_serial_dev (.clk_i(clk_i), .reset_i(reset_i), .clk_en_i(1'b1),
    .link(link), .tick_i(tick), .abort_n_i(abort_n), .power_fail_threshold_i(pwr_fail),
    .mem_ce_n_o(mem_ce_n), .xfer_active_o(xfer_active));
  rtc_serial_sva u_rtc_serial_sva (.clk_i(clk_i), .reset_i(reset_i), .ce_n(link.ce_n),
    .oe_n(link.oe_n), .we_n(link.we_n), .host_dq_oe_n(link.host_dq_oe_n),
    .dev_dq0_oe_n(link.dev_dq0_oe_n), .serial_key_data_line(link.serial_key_data_line),
    .abort_n_i(abort_n), .power_fail_threshold_i(pwr_fail), .mem_ce_n_o(mem_ce_n),
    .xfer_active_o(xfer_active));

  task end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  // A hang anywhere lands here; a full run needs well under a third of this.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_total++;
      end_of_test();
    end
  end

  task compare(input string what, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : compare

  task av(input logic rd, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    av_address <= a;
    av_read    <= rd;
    av_write   <= !rd;
    av_wdata   <= d;
    do @(posedge clk_i); while (waitrequest !== 1'b0);
    q = readdata;
    av_read  <= 1'b0;
    av_write <= 1'b0;
  endtask : av

  task go(input logic dir, input logic [63:0] tx);
    logic [31:0] q;
    av(1'b0, OFS_DATA_LO, tx[31:0], q);
    av(1'b0, OFS_DATA_HI, tx[63:32], q);
    av(1'b0, OFS_CTRL, {30'h0000_0000, dir, 1'b1}, q);
  endtask : go

  task wait_idle();
    logic [31:0] q;
    q = 32'h0000_0001;
    while (q[CTRL_GO_BIT] !== 1'b0) av(1'b1, OFS_CTRL, 32'h0000_0000, q);
  endtask : wait_idle

  task clock_op(input logic dir, input logic [63:0] tx, output logic [63:0] rx);
    logic [31:0] q;
    go(dir, tx);
    wait_idle();
    av(1'b1, OFS_DATA_LO, 32'h0000_0000, q);
    rx[31:0] = q;
    av(1'b1, OFS_DATA_HI, 32'h0000_0000, q);
    rx[63:32] = q;
  endtask : clock_op

  task pulse_tick();
    @(posedge clk_i);
    tick <= 1'b1;
    @(posedge clk_i);
    tick <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : pulse_tick

  task t_reset();
    logic [63:0] rx;
    logic [31:0] q;
    av(1'b1, 4'h2, 32'h0000_0000, q);
    compare("unmapped read", {32'h0000_0000, q}, 64'h0000_0000_0000_0000);
    av(1'b0, OFS_ADDR, 32'h0001_2345, q);
    av(1'b1, OFS_ADDR, 32'h0000_0000, q);
    compare("scratch register", {32'h0000_0000, q}, 64'h0000_0000_0001_2345);
    compare("scratch pin", 64'(link.addr), 64'h0000_0000_0001_2345);
    pulse_tick();
    clock_op(1'b0, 64'h0000_0000_0000_0000, rx);
    compare("reset image", rx, 64'h0001_0131_0000_0000);
  endtask : t_reset

  task t_masks();
    logic [63:0] rx;
    clock_op(1'b1, 64'hFFFF_FFFF_FFFF_FFFF, rx);
    clock_op(1'b0, 64'h0000_0000_0000_0000, rx);
    compare("unused bits", rx, 64'hFF1F_3F37_BF7F_7FFF);
  endtask : t_masks

  // The abort pin is held low throughout; the set mask bit must make it harmless.
  task t_roll(input logic [63:0] start, input logic [63:0] exp);
    logic [63:0] rx;
    @(posedge clk_i);
    abort_n <= 1'b0;
    clock_op(1'b1, start, rx);
    pulse_tick();
    clock_op(1'b0, 64'h0000_0000_0000_0000, rx);
    @(posedge clk_i);
    abort_n <= 1'b1;
    compare("rollover", rx, exp);
  endtask : t_roll

  task t_abort();
    logic [63:0] rx;
    clock_op(1'b1, 64'h2406_1501_1000_0000, rx);
    go(1'b1, 64'hFFFF_FFFF_FFFF_FFFF);
    while (xfer_active !== 1'b1) @(posedge clk_i);
    abort_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    abort_n <= 1'b1;
    wait_idle();
    clock_op(1'b0, 64'h0000_0000_0000_0000, rx);
    compare("abort keeps data", rx, 64'h2406_1501_1000_0000);
  endtask : t_abort

  task t_power_fail();
    logic [63:0] rx;
    @(posedge clk_i);
    pwr_fail <= 1'b1;
    clock_op(1'b1, 64'hFFFF_FFFF_FFFF_FFFF, rx);
    @(posedge clk_i);
    pwr_fail <= 1'b0;
    clock_op(1'b0, 64'h0000_0000_0000_0000, rx);
    compare("power fail", rx, 64'h2406_1501_1000_0000);
  endtask : t_power_fail

  initial begin
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_masks();
    t_roll(64'h2406_1511_1959_5999, 64'h2406_1511_2000_0000);
    t_roll(64'h2406_1511_9159_5999, 64'h2406_1511_B200_0000);
    t_abort();
    t_power_fail();
    end_of_test();
  end
endmodule : hidden_rtc_serial_access_tb

// File: testbench/rtc_serial_sva.sv
/*
  Checker for the SRAM-cycle link between the host end and the clock device.
  Assumes the bench passes in the link pins and the device's gate outputs.
*/
`timescale 1ns/100ps
module rtc_serial_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Link pins
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic host_dq_oe_n,
  input wire logic dev_dq0_oe_n,
  input wire logic serial_key_data_line,
  // Device side
  input wire logic abort_n_i,
  input wire logic power_fail_threshold_i,
  input wire logic mem_ce_n_o,
  input wire logic xfer_active_o
);
  localparam logic [63:0] KEY_BITS = 64'h5CA3_3AC5_5CA3_3AC5;
  logic [7:0] wcnt_q;
  logic [8:0] xcnt_q;
  logic       we_prev_q;
  logic       oe_prev_q;
  logic       abort_q;

  // Write ends are counted since the last read end, as the matcher sees them.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wcnt_q    <= 8'h00;
      xcnt_q    <= 9'h000;
      we_prev_q <= 1'b1;
      oe_prev_q <= 1'b1;
      abort_q   <= 1'b0;
    end else begin
      we_prev_q <= we_n;
      oe_prev_q <= oe_n;
      xcnt_q    <= xfer_active_o ? xcnt_q + 9'h001 : 9'h000;
      abort_q   <= xfer_active_o ? (abort_q | !abort_n_i) : 1'b0;
      if (oe_n && !oe_prev_q) begin
        wcnt_q <= 8'h00;
      end else if (we_n && !we_prev_q) begin
        wcnt_q <= wcnt_q + 8'h01;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_unlock;
    $rose(xfer_active_o);
  endsequence
  sequence s_xfer_end;
    $fell(xfer_active_o) && !abort_q;
  endsequence

  chk_unlock_count: assert property (s_unlock |-> wcnt_q == 8'h40)
    else $error("unlock without 64 key writes");
  chk_xfer_length: assert property (s_xfer_end |-> xcnt_q == 9'h100)
    else $error("transfer phase not 64 cycles long");
  chk_key_stream: assert property ((!we_n && !xfer_active_o && wcnt_q < 8'h40)
    |-> serial_key_data_line == KEY_BITS[wcnt_q[5:0]])
    else $error("key bit out of order");
  chk_mem_blocked: assert property (xfer_active_o |-> mem_ce_n_o)
    else $error("memory enabled in transfer");
  chk_power_block: assert property (power_fail_threshold_i |=> mem_ce_n_o)
    else $error("memory enabled in power fail");
  chk_mem_pass: assert property ((!ce_n && !xfer_active_o && !power_fail_threshold_i)
    |=> !mem_ce_n_o)
    else $error("memory cycle not passed through");
  chk_strobe_width: assert property ($fell(ce_n) |-> !ce_n [*3] ##1 ce_n)
    else $error("strobe width wrong");
  chk_one_direction: assert property ((!oe_n || !we_n) |-> (!ce_n && (oe_n || we_n)))
    else $error("bad strobe combination");
  chk_dev_drive: assert property (!dev_dq0_oe_n
    |-> host_dq_oe_n && (xfer_active_o || $past(xfer_active_o)))
    else $error("device drives line outside transfer");
endmodule : rtc_serial_sva
